// ===== tppwm_consts.vh
// constants for the three-phase pwm timing unit
`ifndef TPPWM_CONSTS_VH
`define TPPWM_CONSTS_VH

`define TPPWM_ADDR_W          4
`define TPPWM_DATA_W          16
`define TPPWM_DEAD_W          10
`define TPPWM_SYNCW_W         8

`define TPPWM_OFS_HALF_PERIOD 4'h0
`define TPPWM_OFS_DEAD_TIME   4'h1
`define TPPWM_OFS_MIN_PULSE   4'h2
`define TPPWM_OFS_SYNC_WIDTH  4'h3
`define TPPWM_OFS_DUTY_A      4'h4
`define TPPWM_OFS_DUTY_B      4'h5
`define TPPWM_OFS_DUTY_C      4'h6
`define TPPWM_OFS_MODE_CTRL   4'h7
`define TPPWM_OFS_SYS_STATUS  4'h8

`define TPPWM_MODE_DOUBLE_BIT 6
`define TPPWM_STAT_HALF_BIT   3

`define TPPWM_RST_HALF_PERIOD 16'h0000
`define TPPWM_RST_DEAD_TIME   10'h000
`define TPPWM_RST_MIN_PULSE   16'h0000
`define TPPWM_RST_SYNC_WIDTH  8'h27
`define TPPWM_RST_DUTY        16'h0000
`define TPPWM_RST_MODE_CTRL   16'h0000

`endif

// ===== tppwm_gate_drv.sv
// gate driver model: gate on-times per sync window
`timescale 1ns/1ns
module tppwm_gate_drv (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        sync,
   input  wire [5:0]  gate,
   output reg  [15:0] on_time [0:5],
   output reg  [15:0] on_pair [0:5],
   output reg  [15:0] period
);
   reg  [15:0] acc [0:5];
   reg  [15:0] tick;
   reg         sync_q;
   integer     i;
   // window spans rise to rise, so output lag only shifts it
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_q <= 1'b0;
         tick <= 16'h0000;
         period <= 16'h0000;
         for (i = 0; i < 6; i = i + 1) begin
            acc[i] <= 16'h0000;
            on_time[i] <= 16'h0000;
            on_pair[i] <= 16'h0000;
         end
      end else begin
         sync_q <= sync;
         tick <= (sync && !sync_q) ? 16'h0001 : tick + 16'h0001;
         if (sync && !sync_q)
            period <= tick;
         for (i = 0; i < 6; i = i + 1) begin
            acc[i] <= (sync && !sync_q) ? {15'h0000, gate[i]} : acc[i] + {15'h0000, gate[i]};
            if (sync && !sync_q) begin
               on_time[i] <= acc[i];
               on_pair[i] <= acc[i] + on_time[i];
            end
         end
      end
   end
endmodule // tppwm_gate_drv

// ===== tppwm_timing_unit.v
// three-phase center-based pwm timing unit with register port
//
// Contract
// - each phase duty count drives its own high/low pair, identical logic.
// - duty count is high-side on-time per half period in ticks.
// - single update mode gives waveforms centered on the period sync; here only low-side pulses are, high-side center mid-period.
// - dead time shifts every switching edge by dead count ticks.
// - single mode high 2x(duty-dead), low 2x(half-duty-dead) ticks.
// - on-times clamp between zero and the full period.
// - double mode period and on-time sum values of both halves.
// - double mode applies dead time per half the same way.
// - status bit 3 shows the active half of the period.
// - outputs off until the first sync after half period and duties written; counters idle until half period written.
// - single mode first sync 1.5 x half period after half-period write.
// - double mode first sync one half period after half-period write.
// - single mode same duty both halves, two-tick full-period steps.
// - double mode latches separate duty values per half period.
// - programmable minimum on-time per half equals min pulse count ticks.
// - shorter outputs held off whole half, complement fully on.
// - half-period register counts ticks in half the pwm period.
// - mode control bit 6 selects double update when set.
// - sync rising edge latches period, dead, min, width and duties.
// - double mode adds a midpoint sync that also latches values.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "tppwm_consts.vh"

module tppwm_timing_unit (
   core_clk,
   rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   period_sync_pulse,
   phase_a_high_out,
   phase_a_low_out,
   phase_b_high_out,
   phase_b_low_out,
   phase_c_high_out,
   phase_c_low_out
);
   input  wire                        core_clk;
   input  wire                        rst;
   input  wire [`TPPWM_ADDR_W-1:0]    reg_addr;
   input  wire [`TPPWM_DATA_W-1:0]    reg_wdata;
   input  wire                        reg_wr;
   input  wire                        reg_rd;
   output reg  [`TPPWM_DATA_W-1:0]    reg_rdata;
   output reg                         period_sync_pulse;
   output wire                        phase_a_high_out;
   output wire                        phase_a_low_out;
   output wire                        phase_b_high_out;
   output wire                        phase_b_low_out;
   output wire                        phase_c_high_out;
   output wire                        phase_c_low_out;

   // software-side shadow registers
   reg  [15:0]                        half_period_reg;
   reg  [`TPPWM_DEAD_W-1:0]           dead_time_reg;
   reg  [15:0]                        min_pulse_reg;
   reg  [`TPPWM_SYNCW_W-1:0]          sync_width_reg;
   reg  [15:0]                        duty_sh_reg [0:2];
   reg  [15:0]                        mode_control_reg;
   reg  [3:0]                         written_reg;

   // values latched into the timing unit
   reg  [15:0]                        tm_l_reg;
   reg  [`TPPWM_DEAD_W-1:0]           dead_l_reg;
   reg  [15:0]                        pd_l_reg;
   reg  [15:0]                        duty_l_reg [0:2];

   reg                                running_reg;
   reg                                primed_reg;
   reg                                half_reg;
   reg  [15:0]                        pos_reg;
   reg  [`TPPWM_SYNCW_W-1:0]          sync_cnt_reg;
   reg  [2:0]                         hi_out_reg;
   reg  [2:0]                         lo_out_reg;

   wire                               double_mode;
   wire                               all_written;
   wire                               tm_first_wr;
   wire [15:0]                        tm_eff;
   wire                               at_end;
   wire                               half_next;
   wire                               new_sync;
   wire [2:0]                         hi_w;
   wire [2:0]                         lo_w;
   integer                            k;
   // separate loop variable so each process owns its own
   integer                            j;

   // mode select bit
   // mode bit
   assign double_mode = mode_control_reg[`TPPWM_MODE_DOUBLE_BIT];
   assign all_written = &written_reg;
   assign tm_first_wr = reg_wr && (reg_addr == `TPPWM_OFS_HALF_PERIOD) && !written_reg[0];
   // zero half period would never wrap; treat as one tick
   assign tm_eff      = (tm_l_reg == 16'h0000) ? 16'h0001 : tm_l_reg;
   assign at_end      = running_reg && (pos_reg == tm_eff - 16'h0001);
   assign half_next   = ~half_reg;
   assign new_sync    = at_end && (double_mode || (half_next == 1'b0));

   // register writes
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_period_reg  <= `TPPWM_RST_HALF_PERIOD;
         dead_time_reg    <= `TPPWM_RST_DEAD_TIME;
         min_pulse_reg    <= `TPPWM_RST_MIN_PULSE;
         sync_width_reg   <= `TPPWM_RST_SYNC_WIDTH;
         mode_control_reg <= `TPPWM_RST_MODE_CTRL;
         written_reg      <= 4'h0;
         for (k = 0; k < 3; k = k + 1) begin
            duty_sh_reg[k] <= `TPPWM_RST_DUTY;
         end
      end else if (reg_wr) begin
         case (reg_addr)
            `TPPWM_OFS_HALF_PERIOD: begin
               half_period_reg <= reg_wdata;
               written_reg[0]  <= 1'b1;
            end
            `TPPWM_OFS_DEAD_TIME:  dead_time_reg  <= reg_wdata[`TPPWM_DEAD_W-1:0];
            `TPPWM_OFS_MIN_PULSE:  min_pulse_reg  <= reg_wdata;
            `TPPWM_OFS_SYNC_WIDTH: sync_width_reg <= reg_wdata[`TPPWM_SYNCW_W-1:0];
            `TPPWM_OFS_DUTY_A: begin
               duty_sh_reg[0] <= reg_wdata;
               written_reg[1] <= 1'b1;
            end
            `TPPWM_OFS_DUTY_B: begin
               duty_sh_reg[1] <= reg_wdata;
               written_reg[2] <= 1'b1;
            end
            `TPPWM_OFS_DUTY_C: begin
               duty_sh_reg[2] <= reg_wdata;
               written_reg[3] <= 1'b1;
            end
            `TPPWM_OFS_MODE_CTRL:  mode_control_reg <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TPPWM_OFS_HALF_PERIOD: reg_rdata <= half_period_reg;
            `TPPWM_OFS_DEAD_TIME:   reg_rdata <= {6'h00, dead_time_reg};
            `TPPWM_OFS_MIN_PULSE:   reg_rdata <= min_pulse_reg;
            `TPPWM_OFS_SYNC_WIDTH:  reg_rdata <= {8'h00, sync_width_reg};
            `TPPWM_OFS_DUTY_A:      reg_rdata <= duty_sh_reg[0];
            `TPPWM_OFS_DUTY_B:      reg_rdata <= duty_sh_reg[1];
            `TPPWM_OFS_DUTY_C:      reg_rdata <= duty_sh_reg[2];
            `TPPWM_OFS_MODE_CTRL:   reg_rdata <= mode_control_reg;
            `TPPWM_OFS_SYS_STATUS:  reg_rdata <= {12'h000, half_reg, 3'h0};
            default:                reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // main timer: position within the current half period
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         running_reg <= 1'b0;
         half_reg    <= 1'b0;
         pos_reg     <= 16'h0000;
         tm_l_reg    <= 16'h0000;
      end else if (tm_first_wr) begin
         running_reg <= 1'b1;
         half_reg    <= 1'b0;
         tm_l_reg    <= reg_wdata;
         pos_reg     <= double_mode ? 16'h0000 : {1'b0, reg_wdata[15:1]};
      end else if (at_end) begin
         half_reg <= half_next;
         pos_reg  <= 16'h0000;
         if (new_sync) begin
            tm_l_reg <= half_period_reg;
         end
      end else if (running_reg) begin
         pos_reg <= pos_reg + 16'h0001;
      end
   end

   // latch of timing values on each sync start
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dead_l_reg <= `TPPWM_RST_DEAD_TIME;
         pd_l_reg   <= `TPPWM_RST_MIN_PULSE;
         primed_reg <= 1'b0;
         for (j = 0; j < 3; j = j + 1) begin
            duty_l_reg[j] <= `TPPWM_RST_DUTY;
         end
      end else if (new_sync) begin
         dead_l_reg <= dead_time_reg;
         pd_l_reg   <= min_pulse_reg;
         for (j = 0; j < 3; j = j + 1) begin
            duty_l_reg[j] <= duty_sh_reg[j];
         end
         if (all_written) begin
            primed_reg <= 1'b1;
         end
      end
   end

   // sync pulse lasts width+1 ticks
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         period_sync_pulse <= 1'b0;
         sync_cnt_reg      <= 8'h00;
      end else if (new_sync) begin
         period_sync_pulse <= 1'b1;
         sync_cnt_reg      <= sync_width_reg;
      end else if (sync_cnt_reg != 8'h00) begin
         sync_cnt_reg <= sync_cnt_reg - 8'h01;
      end else begin
         period_sync_pulse <= 1'b0;
      end
   end

   // per-phase edge placement
   // identical per phase
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : phase
         wire [16:0] duty_x;
         wire [16:0] dead_x;
         wire [16:0] tm_x;
         wire [16:0] pd_x;
         wire [16:0] pos_x;
         wire [16:0] hi_raw;
         wire [16:0] lo_sum;
         wire [16:0] lo_raw;
         wire [16:0] hi_clip;
         wire        hi_short;
         wire        lo_short;
         wire [16:0] hi_on;
         wire [16:0] lo_on;
         assign duty_x  = {1'b0, duty_l_reg[g]};
         assign dead_x  = {7'h00, dead_l_reg};
         assign tm_x    = {1'b0, tm_eff};
         assign pd_x    = {1'b0, pd_l_reg};
         assign pos_x   = {1'b0, pos_reg};
         assign hi_raw  = (duty_x > dead_x) ? duty_x - dead_x : 17'h00000;
         assign lo_sum  = duty_x + dead_x;
         assign lo_raw  = (tm_x > lo_sum) ? tm_x - lo_sum : 17'h00000;
         assign hi_clip = (hi_raw > tm_x) ? tm_x : hi_raw;
         assign hi_short = hi_clip < pd_x;
         assign lo_short = !hi_short && (lo_raw < pd_x);
         assign hi_on   = hi_short ? 17'h00000 : (lo_short ? tm_x : hi_clip);
         assign lo_on   = hi_short ? tm_x : (lo_short ? 17'h00000 : lo_raw);
         assign hi_w[g] = half_reg ? (pos_x < hi_on) : (pos_x >= tm_x - hi_on);
         assign lo_w[g] = half_reg ? (pos_x >= tm_x - lo_on) : (pos_x < lo_on);
      end
   endgenerate

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_out_reg <= 3'h0;
         lo_out_reg <= 3'h0;
      end else if (primed_reg) begin
         hi_out_reg <= hi_w;
         lo_out_reg <= lo_w;
      end else begin
         hi_out_reg <= 3'h0;
         lo_out_reg <= 3'h0;
      end
   end

   assign phase_a_high_out = hi_out_reg[0];
   assign phase_a_low_out  = lo_out_reg[0];
   assign phase_b_high_out = hi_out_reg[1];
   assign phase_b_low_out  = lo_out_reg[1];
   assign phase_c_high_out = hi_out_reg[2];
   assign phase_c_low_out  = lo_out_reg[2];

endmodule // tppwm_timing_unit

// ===== tppwm_timing_unit_checker.sv
// port checker for the pwm timing unit
`timescale 1ns/1ns
module tppwm_chk (
   input wire        core_clk,
   input wire        rst,
   input wire [3:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire        period_sync_pulse,
   input wire        phase_a_high_out,
   input wire        phase_a_low_out,
   input wire        phase_b_high_out,
   input wire        phase_b_low_out,
   input wire        phase_c_high_out,
   input wire        phase_c_low_out
);
   reg  [7:0] sw_sh, w_lat;
   reg  [9:0] dt_sh;
   reg  [8:0] cnt;
   reg  [3:0] seen;
   reg        primed, sync_q;
   wire [5:0] outs = {phase_a_high_out, phase_a_low_out, phase_b_high_out,
                      phase_b_low_out, phase_c_high_out, phase_c_low_out};
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sw_sh <= 8'h27;
         dt_sh <= 10'h000;
         seen <= 4'h0;
         primed <= 1'b0;
         sync_q <= 1'b0;
         cnt <= 9'h000;
         w_lat <= 8'h00;
      end else begin
         sync_q <= period_sync_pulse;
         if (reg_wr && reg_addr == 4'h3)
            sw_sh <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 4'h1)
            dt_sh <= reg_wdata[9:0];
         if (reg_wr)
            seen <= seen | {reg_addr == 4'h6, reg_addr == 4'h5, reg_addr == 4'h4, reg_addr == 4'h0};
         if (&seen && period_sync_pulse)
            primed <= 1'b1;
         if (period_sync_pulse && !sync_q) begin
            cnt <= 9'h001;
            w_lat <= sw_sh;
         end else if (period_sync_pulse)
            cnt <= cnt + 9'h001;
      end
   end
   sequence s_sw_read;
      reg_rd && reg_addr == 4'h3;
   endsequence
   sequence s_gap_a;
      !phase_a_low_out ##1 !phase_a_low_out;
   endsequence
   a_gates_idle: assert property (
      !primed && !(&seen && period_sync_pulse) |-> outs == 6'h00) else $error("gate on early");
   a_rdata_idle: assert property (
      !(reg_rd && reg_addr < 4'h9) |=> reg_rdata == 16'h0000) else $error("stray read data");
   a_width_readback: assert property (
      s_sw_read |=> reg_rdata == {8'h00, sw_sh}) else $error("sync width readback");
   a_sync_width: assert property (
      $fell(period_sync_pulse) |-> cnt == {1'b0, w_lat} + 9'h001) else $error("sync width");
   a_overlap_a: assert property (
      !(phase_a_high_out && phase_a_low_out)) else $error("phase a overlap");
   a_overlap_b: assert property (
      !(phase_b_high_out && phase_b_low_out)) else $error("phase b overlap");
   a_overlap_c: assert property (
      !(phase_c_high_out && phase_c_low_out)) else $error("phase c overlap");
   a_dead_gap: assert property (
      $fell(phase_a_high_out) && dt_sh == 10'h001 |-> s_gap_a) else $error("dead gap short");
endmodule // tppwm_chk
bind tppwm_timing_unit tppwm_chk tppwm_chk_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .period_sync_pulse, .phase_a_high_out, .phase_a_low_out,
   .phase_b_high_out, .phase_b_low_out, .phase_c_high_out, .phase_c_low_out);

// ===== tppwm_timing_unit_tb.sv
// self-checking bench for the pwm timing unit
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tppwm_timing_unit_tb;
   reg         core_clk, rst, reg_wr, reg_rd;
   reg  [3:0]  reg_addr;
   reg  [15:0] reg_wdata, rv;
   wire [15:0] reg_rdata, period;
   wire        period_sync_pulse;
   wire [5:0]  gate;
   wire [15:0] on_time [0:5];
   wire [15:0] on_pair [0:5];
   int         miscompares = 0, n_compared = 0, cyc = 0, t0;
   tppwm_timing_unit tppwm_timing_unit_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .period_sync_pulse, .phase_a_high_out(gate[0]),
      .phase_a_low_out(gate[1]), .phase_b_high_out(gate[2]), .phase_b_low_out(gate[3]),
      .phase_c_high_out(gate[4]), .phase_c_low_out(gate[5]));
   tppwm_gate_drv tppwm_gate_drv_i (.core_clk, .rst, .sync(period_sync_pulse), .gate,
      .on_time, .on_pair, .period);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input [3:0] a, input [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   // bounded: a stuck timer must not hang the run
   task wsync(input int n);
      int k;
      k = 0;
      repeat (n) begin
         while (period_sync_pulse !== 1'b0 && k < 400) begin
            @(posedge core_clk);
            #1 k++;
         end
         while (period_sync_pulse !== 1'b1 && k < 400) begin
            @(posedge core_clk);
            #1 k++;
         end
      end
      if (k >= 400) begin
         miscompares++;
         test_done();
      end
   endtask
   // skip two windows so new values are latched before measuring
   task meas(input [15:0] ah, al, bh, bl, ch, cl);
      wsync(3);
      @(posedge core_clk);
      #1 `CHK(on_time[0], ah)
      `CHK(on_time[1], al)
      `CHK(on_time[2], bh)
      `CHK(on_time[3], bl)
      `CHK(on_time[4], ch)
      `CHK(on_time[5], cl)
   endtask
   task do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      do_reset();
      rd(4'h3);
      `CHK(rv, 16'h0027)
      rd(4'h7);
      `CHK(rv, 16'h0000)
      wr(4'h8, 16'hffff);
      rd(4'h8);
      `CHK(rv, 16'h0000)
      rd(4'hf);
      `CHK(rv, 16'h0000)
      wr(4'h3, 16'h0002);
      wr(4'h1, 16'h0001);
      wr(4'h0, 16'h000a);
      t0 = cyc;
      wr(4'h4, 16'h0005);
      wr(4'h5, 16'h0003);
      wr(4'h6, 16'h0008);
      wsync(1);
      `CHK(cyc - t0 inside {[15:18]}, 1'b1)
      meas(16'h8, 16'h8, 16'h4, 16'hc, 16'he, 16'h2);
      `CHK(period, 16'h0014)
      wr(4'h4, 16'h0000);
      wr(4'h6, 16'h000c);
      meas(16'h0, 16'h12, 16'h4, 16'hc, 16'h14, 16'h0);
      wr(4'h2, 16'h0003);
      wr(4'h4, 16'h0006);
      wr(4'h6, 16'h0008);
      meas(16'ha, 16'h6, 16'h0, 16'h14, 16'h14, 16'h0);
      @(posedge core_clk);
      do_reset();
      wr(4'h7, 16'h0040);
      wr(4'h3, 16'h0002);
      wr(4'h1, 16'h0001);
      wr(4'h0, 16'h000a);
      t0 = cyc;
      wr(4'h4, 16'h0005);
      wr(4'h5, 16'h0005);
      wr(4'h6, 16'h0005);
      wsync(1);
      `CHK(cyc - t0 inside {[10:13]}, 1'b1)
      wsync(2);
      rd(4'h8);
      if (rv[3] === 1'b1)
         wsync(1);
      wr(4'h4, 16'h0006);
      wsync(1);
      rd(4'h8);
      `CHK(rv, 16'h0008)
      wr(4'h4, 16'h0005);
      wsync(1);
      rd(4'h8);
      `CHK(rv, 16'h0000)
      wr(4'h4, 16'h0006);
      wsync(2);
      @(posedge core_clk);
      #1 `CHK(on_pair[0], 16'h0009)
      `CHK(on_pair[1], 16'h0007)
      `CHK(period, 16'h000a)
      test_done();
   end
endmodule // tppwm_timing_unit_tb
